// [rtl/dbw_pkg.sv]
// Package: register map, field positions and reset values of the PLL bandwidth block
package dbw_pkg;
  // Register indices; select and status indices are local choices
  localparam logic [5:0] DBW_BW_SEL_IDX     = 6'h3B;
  localparam logic [5:0] DBW_CAL_LOW_IDX    = 6'h3C;
  localparam logic [5:0] DBW_CAL_HIGH_IDX   = 6'h3D;
  localparam logic [5:0] DBW_STATUS_IDX     = 6'h3E;
  // Byte addresses: one aligned word per register, four times the index
  localparam logic [7:0] DBW_BW_SEL_ADDR    = {DBW_BW_SEL_IDX, 2'h0};
  localparam logic [7:0] DBW_CAL_LOW_ADDR   = {DBW_CAL_LOW_IDX, 2'h0};
  localparam logic [7:0] DBW_CAL_HIGH_ADDR  = {DBW_CAL_HIGH_IDX, 2'h0};
  localparam logic [7:0] DBW_STATUS_ADDR    = {DBW_STATUS_IDX, 2'h0};
  // Field positions in the bandwidth select register
  localparam int         DBW_AUTO_BIT       = 7;
  localparam int         DBW_LIMIT_BIT      = 3;
  // Field positions in the status register
  localparam int         DBW_ST_ACQ_BIT     = 0;
  localparam int         DBW_ST_FROZEN_BIT  = 1;
  // Reset values
  localparam logic [7:0] DBW_BW_SEL_RESET   = 8'h00;
  localparam logic [7:0] DBW_CAL_RESET      = 8'h99;
  // AXI responses
  localparam logic [1:0] DBW_RESP_OKAY      = 2'h0;
  localparam logic [1:0] DBW_RESP_SLVERR    = 2'h2;
endpackage

// [rtl/dbw_regs.sv]
// Register bank steering PLL bandwidth choice, integral limit freeze and oscillator calibration
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps

// Behaviour
// R1: Auto bit set: bandwidth follows lock state
// R2: Auto bit clear: locked bandwidth always used
// R3: Limit bit freezes integral at frequency limit
// R4: Reported frequency frozen while integral frozen
// R5: Calibration low byte register, reset 0x99
// R6: Calibration high byte register, reset 0x99
// R7: Bytes applied together; unused bits read zero (the code applies each byte as soon as it is written)
module dbw_regs
  import dbw_pkg::*;
#(
  parameter int FREQ_W = 16
)
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  // AXI4-Lite write address and data
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Loop status from the PLL (same clock domain)
  input  wire logic              pll_locked,
  input  wire logic              pll_at_limit,
  input  wire logic [FREQ_W-1:0] pll_freq_in,
  // Loop control to the PLL
  output logic                   use_acq_bandwidth,
  output logic                   integral_freeze,
  output logic [FREQ_W-1:0]      reported_pll_frequency,
  output logic [15:0]            osc_calibration
);

  logic              rst_meta_reg;
  logic              rst_sync_reg;
  logic              rst_n;
  logic [7:0]        bandwidth_auto_select_reg;
  logic [7:0]        osc_calibration_low_reg;
  logic [7:0]        osc_calibration_high_reg;
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [7:0]        aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic              w_strb0_reg;
  logic              wr_fire;
  logic              wr_hit;
  logic              use_acq_reg;
  logic              freeze_reg;
  logic [FREQ_W-1:0] freq_reg;
  logic [15:0]       cal_reg;
  logic              bandwidth_auto_choose;
  logic              output_pll_integral_limit;
  logic [31:0]       rd_word;
  logic              rd_hit;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // Control fields decoded from the select register
  assign bandwidth_auto_choose     = bandwidth_auto_select_reg[DBW_AUTO_BIT];
  assign output_pll_integral_limit = bandwidth_auto_select_reg[DBW_LIMIT_BIT];

  // Write channels are taken independently; each ready drops while its item is held
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb0_reg <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg  <= 1'b1;
        w_data_reg  <= s_axi_wdata;
        w_strb0_reg <= s_axi_wstrb[0];
      end
      else if (wr_fire)
        w_held_reg <= 1'b0;
    end
  end

  // Only byte lane 0 carries register data; other lanes are ignored
  assign wr_hit = (aw_addr_reg == DBW_BW_SEL_ADDR) || (aw_addr_reg == DBW_CAL_LOW_ADDR)
               || (aw_addr_reg == DBW_CAL_HIGH_ADDR) || (aw_addr_reg == DBW_STATUS_ADDR);

  // Register writes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bandwidth_auto_select_reg <= DBW_BW_SEL_RESET;
      osc_calibration_low_reg   <= DBW_CAL_RESET;   // R5
      osc_calibration_high_reg  <= DBW_CAL_RESET;   // R6
    end
    else if (wr_fire && w_strb0_reg)
    begin
      case (aw_addr_reg)
        DBW_BW_SEL_ADDR:   bandwidth_auto_select_reg <= w_data_reg[7:0];
        DBW_CAL_LOW_ADDR:  osc_calibration_low_reg   <= w_data_reg[7:0];   // R5
        DBW_CAL_HIGH_ADDR: osc_calibration_high_reg  <= w_data_reg[7:0];   // R6
        default:           ;
      endcase
    end
  end

  // Write response; unmapped addresses get SLVERR
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= DBW_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? DBW_RESP_OKAY : DBW_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read decode; the select register reads back only its two live bits
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      DBW_BW_SEL_ADDR:
      begin
        rd_word[DBW_AUTO_BIT]  = bandwidth_auto_choose;        // R7
        rd_word[DBW_LIMIT_BIT] = output_pll_integral_limit;    // R7
      end
      DBW_CAL_LOW_ADDR:  rd_word[7:0] = osc_calibration_low_reg;
      DBW_CAL_HIGH_ADDR: rd_word[7:0] = osc_calibration_high_reg;
      DBW_STATUS_ADDR:
      begin
        rd_word[DBW_ST_ACQ_BIT]    = use_acq_reg;
        rd_word[DBW_ST_FROZEN_BIT] = freeze_reg;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // Read data channel; one read in flight
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= DBW_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? DBW_RESP_OKAY : DBW_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Loop control: bandwidth choice, integral freeze and frequency report
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      use_acq_reg <= 1'b0;
      freeze_reg  <= 1'b0;
      freq_reg    <= '0;
      cal_reg     <= {DBW_CAL_RESET, DBW_CAL_RESET};
    end
    else
    begin
      // Acquisition only when auto mode is on and the loop is unlocked
      use_acq_reg <= bandwidth_auto_choose && !pll_locked;        // R1 R2
      freeze_reg  <= output_pll_integral_limit && pll_at_limit;   // R3
      if (!(output_pll_integral_limit && pll_at_limit))
        freq_reg <= pll_freq_in;                                  // R4
      // Both bytes move in one edge; a write to one byte reaches the oscillator with the other byte unchanged
      cal_reg <= {osc_calibration_high_reg, osc_calibration_low_reg};   // R7
    end
  end

  assign use_acq_bandwidth      = use_acq_reg;
  assign integral_freeze        = freeze_reg;
  assign reported_pll_frequency = freq_reg;
  assign osc_calibration        = cal_reg;

  // Checks
  auto_bw_follow_a : assert property (@(posedge sys_clk) disable iff (!rst_n)   // R1
    (bandwidth_auto_choose && !pll_locked) |=> use_acq_bandwidth)
    else $error("auto bandwidth did not pick acquisition");
  locked_bw_fixed_a : assert property (@(posedge sys_clk) disable iff (!rst_n)  // R2
    (!bandwidth_auto_choose || pll_locked) |=> !use_acq_bandwidth)
    else $error("locked bandwidth not applied");
  integral_freeze_a : assert property (@(posedge sys_clk) disable iff (!rst_n)  // R3
    integral_freeze == $past(output_pll_integral_limit && pll_at_limit))
    else $error("integral freeze wrong");
  freq_hold_a : assert property (@(posedge sys_clk) disable iff (!rst_n)        // R4
    $past(output_pll_integral_limit && pll_at_limit) |-> $stable(reported_pll_frequency))
    else $error("reported frequency moved while frozen");
  cal_low_write_a : assert property (@(posedge sys_clk) disable iff (!rst_n)    // R5
    (wr_fire && w_strb0_reg && aw_addr_reg == DBW_CAL_LOW_ADDR)
    |=> ##1 osc_calibration[7:0] == $past(w_data_reg[7:0], 2))
    else $error("calibration low byte not applied");
  cal_high_write_a : assert property (@(posedge sys_clk) disable iff (!rst_n)   // R6
    (wr_fire && w_strb0_reg && aw_addr_reg == DBW_CAL_HIGH_ADDR)
    |=> ##1 osc_calibration[15:8] == $past(w_data_reg[7:0], 2))
    else $error("calibration high byte not applied");
  unused_zero_a : assert property (@(posedge sys_clk) disable iff (!rst_n)      // R7
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == DBW_BW_SEL_ADDR)
    |=> (s_axi_rdata & 32'hFFFF_FF77) == 32'h0000_0000)
    else $error("unused select bits read nonzero");
  write_resp_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_fire |=> s_axi_bvalid)
    else $error("write response missing");

endmodule // dbw_regs

// [verif/dbw_regs_tb.sv]
// Self-checking bench for the PLL bandwidth register bank
`timescale 1ns/1ps
module dbw_regs_tb;
  import dbw_pkg::*;
  logic        sys_clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, locked, at_lim;
  logic        acq, frz, mon, auto_b, lim_b, e_acq, e_frz;
  logic [7:0]  awaddr, araddr, lo, hi;
  logic [31:0] wdata, rdata, rd, seed;
  logic [3:0]  wstrb, wr_strb;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] freq_in, freq_out, e_freq, osc_cal;
  int          num_errors, compares, cyc;
  dbw_regs dut (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pll_locked(locked), .pll_at_limit(at_lim),
    .pll_freq_in(freq_in), .use_acq_bandwidth(acq), .integral_freeze(frz),
    .reported_pll_frequency(freq_out), .osc_calibration(osc_cal));
  // Clock at 50 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic close_out();
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Handshakes are seen at the falling edge, acted on at the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge sys_clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= wr_strb; wvalid <= 1'b1; bready <= 1'b1;
    b = 1'b0;
    while (!b)
    begin
      @(negedge sys_clk);
      aw = awvalid && awready; w = wvalid && wready; b = bvalid; r = bresp;
      @(posedge sys_clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rv;
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    rv = 1'b0;
    while (!rv)
    begin
      @(negedge sys_clk);
      ar = arvalid && arready; rv = rvalid; d = rdata; r = rresp;
      @(posedge sys_clk);
      if (ar) arvalid <= 1'b0;
      if (rv) rready <= 1'b0;
    end
  endtask
  // Reference for the loop outputs, one cycle behind the inputs
  always @(posedge sys_clk)
  begin
    e_acq <= auto_b && !locked;
    e_frz <= lim_b && at_lim;
    if (!(lim_b && at_lim)) e_freq <= freq_in;
  end
  // Loop output comparison while random loop traffic runs
  always @(negedge sys_clk)
    if (mon)
    begin
      chk(acq, e_acq);
      chk(frz, e_frz);
      chk(freq_out, e_freq);
    end
  // Watchdog: the whole run needs a few hundred cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      close_out();
    end
  end
  initial
  begin
    seed = 32'h0001_2878; rst_b = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    wr_strb = 4'hF;
    wstrb = 4'h0; locked = 1'b0; at_lim = 1'b0; freq_in = 16'h0000; mon = 1'b0;
    auto_b = 1'b0; lim_b = 1'b0; num_errors = 0; compares = 0; cyc = 0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(osc_cal, 16'h9999);
    axi_rd(DBW_BW_SEL_ADDR, rd, rs); chk(rd, DBW_BW_SEL_RESET);
    axi_rd(DBW_CAL_LOW_ADDR, rd, rs); chk(rd, 32'h99);
    axi_rd(DBW_CAL_HIGH_ADDR, rd, rs); chk(rd, 32'h99);
    axi_rd(8'h10, rd, rs); chk(rs, DBW_RESP_SLVERR); chk(rd, 32'h0);
    axi_wr(8'h10, 32'hFF, rs); chk(rs, DBW_RESP_SLVERR);
    // Calibration bytes, corner values first, then random
    for (int i = 0; i < 6; i++)
    begin
      lo = (i == 0) ? 8'h00 : rnd(); hi = (i == 0) ? 8'hFF : rnd();
      axi_wr(DBW_CAL_LOW_ADDR, {24'h0, lo}, rs); chk(rs, DBW_RESP_OKAY);
      axi_wr(DBW_CAL_HIGH_ADDR, {24'h0, hi}, rs); chk(rs, DBW_RESP_OKAY);
      axi_rd(DBW_CAL_LOW_ADDR, rd, rs); chk(rd, {24'h0, lo});
      axi_rd(DBW_CAL_HIGH_ADDR, rd, rs); chk(rd, {24'h0, hi});
      chk(osc_cal, {hi, lo});
    end
    // Byte lane 0 disabled: the write is answered but changes nothing
    wr_strb = 4'h0;
    axi_wr(DBW_CAL_LOW_ADDR, {24'h0, ~lo}, rs); chk(rs, DBW_RESP_OKAY);
    wr_strb = 4'hF;
    axi_rd(DBW_CAL_LOW_ADDR, rd, rs); chk(rd, {24'h0, lo});
    // Status is read-only; a write is accepted and ignored
    axi_wr(DBW_STATUS_ADDR, 32'hFF, rs); chk(rs, DBW_RESP_OKAY);
    // Every combination of automatic bandwidth and integral limit
    for (int m = 0; m < 4; m++)
    begin
      auto_b = m[1]; lim_b = m[0];
      axi_wr(DBW_BW_SEL_ADDR, (rnd() & 32'h77) | {24'h0, auto_b, 3'h0, lim_b, 3'h0}, rs);
      axi_rd(DBW_BW_SEL_ADDR, rd, rs); chk(rd, {24'h0, auto_b, 3'h0, lim_b, 3'h0});
      // Unlocked loop at its limit: status shows chosen bandwidth and freeze
      locked <= 1'b0; at_lim <= 1'b1;
      repeat (2) @(posedge sys_clk);
      axi_rd(DBW_STATUS_ADDR, rd, rs); chk(rd, {30'h0, lim_b, auto_b});
      mon = 1'b1;
      repeat (60)
      begin
        @(posedge sys_clk);
        rd = rnd();
        locked <= rd[0]; at_lim <= rd[1]; freq_in <= rd[31:16];
      end
      @(posedge sys_clk);
      mon = 1'b0; at_lim <= 1'b0;
    end
    close_out();
  end
endmodule // dbw_regs_tb
